/* isd_pkg.sv */
// Constants and helpers for the input stream delay configuration block
// Contract
// - Mode low: delay equals field over four
// - Mode low: up to 7.75 bits, quarter steps
// - Mode low: base sampling point three quarters
// - Mode high: low bits pick sampling point
// - Mode high: upper bits give integer delay
// - Point codes 00/01/10/11 give 3,4,1,2
// - Thirty-two channel delay registers, consecutive
// - Bits 8:0 hold channel delay, reset zero
// - Storage delayed by slots from frame boundary
// - Usable delay limited by stream rate
// - 32 Mbps mode: only first sixteen apply
// - One mode bit selects all field meanings
// - Each local stream has 5-bit field
package isd_pkg;
  localparam int          NUM_STREAMS    = 32;
  localparam int          HALF_STREAMS   = 16;
  localparam int          BIT_FIELD_W    = 5;
  localparam int          CHAN_FIELD_W   = 9;
  localparam int          POS_W          = 6;
  localparam int          RATE_W         = 3;
  // Register indices; byte address is four times the index
  localparam logic [6:0]  IDX_CTRL       = 7'h01;
  localparam logic [6:0]  IDX_STAT       = 7'h02;
  localparam logic [6:0]  IDX_LID_FIRST  = 7'h23;
  localparam logic [6:0]  IDX_LID_LAST   = 7'h42;
  localparam logic [6:0]  IDX_BCD_FIRST  = 7'h43;
  localparam logic [6:0]  IDX_BCD_LAST   = 7'h62;
  // Control register fields
  localparam int          CTRL_MODE_BIT  = 0;
  localparam int          CTRL_RATE_LSB  = 1;
  localparam int          CTRL_RATE_MSB  = 3;
  localparam logic [RATE_W-1:0] RATE_2M  = 3'h0;
  localparam logic [RATE_W-1:0] RATE_4M  = 3'h1;
  localparam logic [RATE_W-1:0] RATE_8M  = 3'h2;
  localparam logic [RATE_W-1:0] RATE_16M = 3'h3;
  localparam logic [RATE_W-1:0] RATE_32M = 3'h4;
  // Status register fields
  localparam int          STAT_CHAN_LSB  = 0;
  localparam int          STAT_FRM_LSB   = 16;
  // Reset values
  localparam logic [BIT_FIELD_W-1:0]  LID_RESET  = 5'h00;
  localparam logic [CHAN_FIELD_W-1:0] BCD_RESET  = 9'h000;
  localparam logic [RATE_W-1:0]       RATE_RESET = 3'h0;
  // Sampling position constant in quarter bits, and bus response codes
  localparam logic [POS_W-1:0]  DEFAULT_POINT    = 6'h03;
  localparam logic [1:0]        RESP_OKAY        = 2'h0;
  localparam logic [1:0]        RESP_DECERR      = 2'h3;

  // Largest usable channel delay for a stream rate
  function automatic logic [CHAN_FIELD_W-1:0] rate_limit(
    input logic [RATE_W-1:0] rate);
    unique case (rate)
      RATE_2M:  rate_limit = 9'h01f;
      RATE_4M:  rate_limit = 9'h03f;
      RATE_8M:  rate_limit = 9'h07f;
      RATE_16M: rate_limit = 9'h0ff;
      default:  rate_limit = 9'h1ff;
    endcase
  endfunction
endpackage

/* isd_bit_delay_dec.sv */
// Decoder of one local stream bit delay field into a sampling position
`timescale 1ns/1ns
module isd_bit_delay_dec
  import isd_pkg::*;
(
  input  wire logic                   mode_in,
  input  wire logic [BIT_FIELD_W-1:0] field_in,
  output logic      [POS_W-1:0]       sample_pos_out,
  output logic      [2:0]             int_delay_out,
  output logic      [2:0]             point_out
);
  wire logic [1:0] local_sample_point_bits;
  wire logic [2:0] local_integer_delay_bits;
  logic      [2:0] point_quarter;

  assign local_sample_point_bits  = field_in[1:0];
  assign local_integer_delay_bits = field_in[4:2];

  always_comb begin
    unique case (local_sample_point_bits)
      2'h0: point_quarter = 3'h3;
      2'h1: point_quarter = 3'h4;
      2'h2: point_quarter = 3'h1;
      2'h3: point_quarter = 3'h2;
    endcase
  end

  // Position counted in quarter bits from the start of the bit
  wire logic [POS_W-1:0] pos_frac;
  wire logic [POS_W-1:0] pos_int;
  assign pos_frac = DEFAULT_POINT + {1'b0, field_in};
  assign pos_int  = {1'b0, local_integer_delay_bits, 2'h0}
                  + {3'h0, point_quarter};

  assign sample_pos_out = mode_in ? pos_int : pos_frac;
  assign int_delay_out  = mode_in ? local_integer_delay_bits : field_in[4:2];
  assign point_out      = mode_in ? point_quarter : DEFAULT_POINT[2:0];
endmodule

/* isd_top.sv */
// Register file and frame-aligned delay control for input streams
//
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/1ns
module isd_top
  import isd_pkg::*;
#(
  parameter int ADDR_W = 12
)(
  input  wire logic                              SYS_CLK_IN,
  input  wire logic                              RST_IN,
  input  wire logic                              CE_IN,
  input  wire logic [ADDR_W-1:0]                 S_AXI_AWADDR_IN,
  input  wire logic                              S_AXI_AWVALID_IN,
  output logic                                   S_AXI_AWREADY_OUT,
  input  wire logic [31:0]                       S_AXI_WDATA_IN,
  input  wire logic [3:0]                        S_AXI_WSTRB_IN,
  input  wire logic                              S_AXI_WVALID_IN,
  output logic                                   S_AXI_WREADY_OUT,
  output logic [1:0]                             S_AXI_BRESP_OUT,
  output logic                                   S_AXI_BVALID_OUT,
  input  wire logic                              S_AXI_BREADY_IN,
  input  wire logic [ADDR_W-1:0]                 S_AXI_ARADDR_IN,
  input  wire logic                              S_AXI_ARVALID_IN,
  output logic                                   S_AXI_ARREADY_OUT,
  output logic [31:0]                            S_AXI_RDATA_OUT,
  output logic [1:0]                             S_AXI_RRESP_OUT,
  output logic                                   S_AXI_RVALID_OUT,
  input  wire logic                              S_AXI_RREADY_IN,
  input  wire logic                              FRAME_START_IN,
  input  wire logic                              CHAN_SLOT_IN,
  output logic                                   SAMPLE_MODE_OUT,
  output logic [NUM_STREAMS*POS_W-1:0]           LOCAL_SAMPLE_POS_OUT,
  output logic [NUM_STREAMS*CHAN_FIELD_W-1:0]    BP_CHAN_DELAY_OUT,
  output logic [NUM_STREAMS-1:0]                 BP_STREAM_ACTIVE_OUT,
  output logic [NUM_STREAMS-1:0]                 BP_STORE_EN_OUT
);
  // Software-visible registers
  logic [BIT_FIELD_W-1:0]  local_bit_delay_reg   [NUM_STREAMS];
  logic [CHAN_FIELD_W-1:0] backplane_chan_delay_reg [NUM_STREAMS];
  logic                    sample_mode_select;
  logic [RATE_W-1:0]       bp_rate;
  // Copies in force for the current frame
  logic [BIT_FIELD_W-1:0]  lid_act [NUM_STREAMS];
  logic [CHAN_FIELD_W-1:0] bcd_act [NUM_STREAMS];
  logic                    mode_act;
  logic [RATE_W-1:0]       rate_act;
  // Frame position
  logic [CHAN_FIELD_W-1:0] chan_count;
  logic [15:0]             frame_count;
  // Bus state
  logic                    bvalid;
  logic [1:0]              bresp;
  logic                    rvalid;
  logic [1:0]              rresp;
  logic [31:0]             rdata;

  // Write decode
  wire logic              wr_fire;
  wire logic [6:0]        wr_idx;
  wire logic              wr_upper_ok;
  wire logic              wr_ctrl;
  wire logic              wr_lid;
  wire logic              wr_bcd;
  wire logic [6:0]        wr_lid_off;
  wire logic [6:0]        wr_bcd_off;
  wire logic              wr_hit;

  assign S_AXI_AWREADY_OUT = CE_IN && !bvalid
                           && S_AXI_AWVALID_IN && S_AXI_WVALID_IN;
  assign S_AXI_WREADY_OUT  = S_AXI_AWREADY_OUT;
  assign wr_fire     = S_AXI_AWREADY_OUT;
  assign wr_idx      = S_AXI_AWADDR_IN[8:2];
  assign wr_upper_ok = (S_AXI_AWADDR_IN[ADDR_W-1:9] == '0);
  assign wr_ctrl     = wr_upper_ok && (wr_idx == IDX_CTRL);
  assign wr_lid      = wr_upper_ok && (wr_idx >= IDX_LID_FIRST)
                     && (wr_idx <= IDX_LID_LAST);
  assign wr_bcd      = wr_upper_ok && (wr_idx >= IDX_BCD_FIRST)
                     && (wr_idx <= IDX_BCD_LAST);
  assign wr_lid_off  = wr_idx - IDX_LID_FIRST;
  assign wr_bcd_off  = wr_idx - IDX_BCD_FIRST;
  assign wr_hit      = wr_ctrl || wr_lid || wr_bcd
                     || (wr_upper_ok && (wr_idx == IDX_STAT));

  // Read decode
  wire logic              rd_fire;
  wire logic [6:0]        rd_idx;
  wire logic              rd_upper_ok;
  wire logic              rd_ctrl;
  wire logic              rd_stat;
  wire logic              rd_lid;
  wire logic              rd_bcd;
  wire logic [6:0]        rd_lid_off;
  wire logic [6:0]        rd_bcd_off;
  wire logic [31:0]       rd_value;
  wire logic              rd_hit;

  assign S_AXI_ARREADY_OUT = CE_IN && !rvalid;
  assign rd_fire     = S_AXI_ARREADY_OUT && S_AXI_ARVALID_IN;
  assign rd_idx      = S_AXI_ARADDR_IN[8:2];
  assign rd_upper_ok = (S_AXI_ARADDR_IN[ADDR_W-1:9] == '0);
  assign rd_ctrl     = rd_upper_ok && (rd_idx == IDX_CTRL);
  assign rd_stat     = rd_upper_ok && (rd_idx == IDX_STAT);
  assign rd_lid      = rd_upper_ok && (rd_idx >= IDX_LID_FIRST)
                     && (rd_idx <= IDX_LID_LAST);
  assign rd_bcd      = rd_upper_ok && (rd_idx >= IDX_BCD_FIRST)
                     && (rd_idx <= IDX_BCD_LAST);
  assign rd_lid_off  = rd_idx - IDX_LID_FIRST;
  assign rd_bcd_off  = rd_idx - IDX_BCD_FIRST;
  assign rd_hit      = rd_ctrl || rd_stat || rd_lid || rd_bcd;
  // Reserved bits read as zero
  assign rd_value =
      rd_ctrl ? {28'h0, bp_rate, sample_mode_select} :
      rd_stat ? {frame_count, 7'h0, chan_count} :
      rd_lid  ? {27'h0, local_bit_delay_reg[rd_lid_off[4:0]]} :
      rd_bcd  ? {23'h0, backplane_chan_delay_reg[rd_bcd_off[4:0]]} :
                32'h0;

  // Register writes; only the defined bits are stored, since software
  // keeps the reserved upper bits at zero anyway
  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      sample_mode_select <= 1'b0;
      bp_rate            <= RATE_RESET;
      for (int i = 0; i < NUM_STREAMS; i++) begin
        local_bit_delay_reg[i]      <= LID_RESET;
        backplane_chan_delay_reg[i] <= BCD_RESET;
      end
    end else if (wr_fire) begin
      if (wr_ctrl && S_AXI_WSTRB_IN[0]) begin
        sample_mode_select <= S_AXI_WDATA_IN[CTRL_MODE_BIT];
        bp_rate <= S_AXI_WDATA_IN[CTRL_RATE_MSB:CTRL_RATE_LSB];
      end
      if (wr_lid && S_AXI_WSTRB_IN[0]) begin
        local_bit_delay_reg[wr_lid_off[4:0]] <=
          S_AXI_WDATA_IN[BIT_FIELD_W-1:0];
      end
      if (wr_bcd && S_AXI_WSTRB_IN[0]) begin
        backplane_chan_delay_reg[wr_bcd_off[4:0]][7:0] <=
          S_AXI_WDATA_IN[7:0];
      end
      if (wr_bcd && S_AXI_WSTRB_IN[1]) begin
        backplane_chan_delay_reg[wr_bcd_off[4:0]][8] <=
          S_AXI_WDATA_IN[8];
      end
    end
  end

  // Write response
  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      bvalid <= 1'b0;
      bresp  <= RESP_OKAY;
    end else if (CE_IN) begin
      if (wr_fire) begin
        bvalid <= 1'b1;
        bresp  <= wr_hit ? RESP_OKAY : RESP_DECERR;
      end else if (S_AXI_BREADY_IN) begin
        bvalid <= 1'b0;
      end
    end
  end

  // Read response
  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      rvalid <= 1'b0;
      rresp  <= RESP_OKAY;
      rdata  <= 32'h0;
    end else if (CE_IN) begin
      if (rd_fire) begin
        rvalid <= 1'b1;
        rresp  <= rd_hit ? RESP_OKAY : RESP_DECERR;
        rdata  <= rd_value;
      end else if (S_AXI_RREADY_IN) begin
        rvalid <= 1'b0;
      end
    end
  end

  assign S_AXI_BVALID_OUT = bvalid;
  assign S_AXI_BRESP_OUT  = bresp;
  assign S_AXI_RVALID_OUT = rvalid;
  assign S_AXI_RRESP_OUT  = rresp;
  assign S_AXI_RDATA_OUT  = rdata;

  // Settings are copied only at a frame start, so a frame that is
  // already being received never sees a mix of old and new delays
  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      mode_act <= 1'b0;
      rate_act <= RATE_RESET;
      for (int i = 0; i < NUM_STREAMS; i++) begin
        lid_act[i] <= LID_RESET;
        bcd_act[i] <= BCD_RESET;
      end
    end else if (CE_IN && FRAME_START_IN) begin
      mode_act <= sample_mode_select;
      rate_act <= bp_rate;
      for (int i = 0; i < NUM_STREAMS; i++) begin
        lid_act[i] <= local_bit_delay_reg[i];
        bcd_act[i] <= backplane_chan_delay_reg[i];
      end
    end
  end

  // Channel slot counter from the frame boundary; it saturates so a
  // long frame cannot wrap and re-close the storage window
  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      chan_count  <= '0;
      frame_count <= 16'h0000;
    end else if (CE_IN) begin
      if (FRAME_START_IN) begin
        chan_count  <= '0;
        frame_count <= frame_count + 16'h0001;
      end else if (CHAN_SLOT_IN && (chan_count != '1)) begin
        chan_count  <= chan_count + 9'h001;
      end
    end
  end

  // Effective channel delay per backplane stream
  wire logic                    bp_is_32m;
  wire logic [CHAN_FIELD_W-1:0] bp_limit;
  assign bp_is_32m = (rate_act >= RATE_32M);
  assign bp_limit  = rate_limit(rate_act);

  logic [CHAN_FIELD_W-1:0] eff_delay   [NUM_STREAMS];
  logic [NUM_STREAMS-1:0]  active;
  always_comb begin
    for (int i = 0; i < NUM_STREAMS; i++) begin
      active[i] = !bp_is_32m || (i < HALF_STREAMS);
      if (!active[i]) begin
        eff_delay[i] = '0;
      end else if (bcd_act[i] > bp_limit) begin
        eff_delay[i] = bp_limit;
      end else begin
        eff_delay[i] = bcd_act[i];
      end
    end
  end

  // Local sampling position decoders
  wire logic [POS_W-1:0] dec_pos [NUM_STREAMS];
  for (genvar g = 0; g < NUM_STREAMS; g++) begin : g_dec
    isd_bit_delay_dec u_dec (
      .mode_in        (mode_act),
      .field_in       (lid_act[g]),
      .sample_pos_out (dec_pos[g]),
      .int_delay_out  (),
      .point_out      ()
    );
  end

  // Registered data outputs
  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      SAMPLE_MODE_OUT      <= 1'b0;
      LOCAL_SAMPLE_POS_OUT <= {NUM_STREAMS{DEFAULT_POINT}};
      BP_CHAN_DELAY_OUT    <= '0;
      BP_STREAM_ACTIVE_OUT <= '1;
      BP_STORE_EN_OUT      <= '0;
    end else if (CE_IN) begin
      SAMPLE_MODE_OUT <= mode_act;
      for (int i = 0; i < NUM_STREAMS; i++) begin
        LOCAL_SAMPLE_POS_OUT[i*POS_W +: POS_W]           <= dec_pos[i];
        BP_CHAN_DELAY_OUT[i*CHAN_FIELD_W +: CHAN_FIELD_W] <= eff_delay[i];
        BP_STREAM_ACTIVE_OUT[i] <= active[i];
        BP_STORE_EN_OUT[i] <= active[i] && !FRAME_START_IN
                            && (chan_count >= eff_delay[i]);
      end
    end
  end
endmodule

/* isd_sva.sv */
// Assertion checker for the input stream delay block
`timescale 1ns/1ns
module isd_sva
  import isd_pkg::*;
(
  input wire logic                            SYS_CLK_IN,
  input wire logic                            RST_IN,
  input wire logic                            CE_IN,
  input wire logic                            FRAME_START_IN,
  input wire logic                            S_AXI_AWVALID_IN,
  input wire logic                            S_AXI_AWREADY_OUT,
  input wire logic                            S_AXI_WVALID_IN,
  input wire logic                            S_AXI_WREADY_OUT,
  input wire logic [1:0]                      S_AXI_BRESP_OUT,
  input wire logic                            S_AXI_BVALID_OUT,
  input wire logic                            S_AXI_BREADY_IN,
  input wire logic                            S_AXI_ARVALID_IN,
  input wire logic                            S_AXI_ARREADY_OUT,
  input wire logic                            S_AXI_RVALID_OUT,
  input wire logic                            S_AXI_RREADY_IN,
  input wire logic                            SAMPLE_MODE_OUT,
  input wire logic [NUM_STREAMS*POS_W-1:0]    LOCAL_SAMPLE_POS_OUT,
  input wire logic [NUM_STREAMS*CHAN_FIELD_W-1:0] BP_CHAN_DELAY_OUT,
  input wire logic [NUM_STREAMS-1:0]          BP_STREAM_ACTIVE_OUT,
  input wire logic [NUM_STREAMS-1:0]          BP_STORE_EN_OUT
);
  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (RST_IN);
  property p_wr_ans;
    S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT |=> S_AXI_BVALID_OUT;
  endproperty
  a_wr_ans: assert property (p_wr_ans) else $error("write answer late");
  // Data lane is taken only together with the address, never while busy
  property p_w_join;
    S_AXI_WREADY_OUT |-> S_AXI_AWVALID_IN && S_AXI_WVALID_IN
      && !S_AXI_BVALID_OUT && CE_IN;
  endproperty
  a_w_join: assert property (p_w_join) else $error("early write");
  property p_rd_ans;
    S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT |=> S_AXI_RVALID_OUT;
  endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read answer late");
  property p_b_hold;
    S_AXI_BVALID_OUT && !S_AXI_BREADY_IN |=>
      S_AXI_BVALID_OUT && $stable(S_AXI_BRESP_OUT);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  property p_r_hold;
    S_AXI_RVALID_OUT && !S_AXI_RREADY_IN |=> S_AXI_RVALID_OUT;
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
  property p_low_act;
    BP_STREAM_ACTIVE_OUT[HALF_STREAMS-1:0] == 16'hffff;
  endproperty
  a_low_act: assert property (p_low_act) else $error("low stream idle");
  property p_idle_zero;
    !BP_STREAM_ACTIVE_OUT[NUM_STREAMS-1] |->
      BP_CHAN_DELAY_OUT[NUM_STREAMS*CHAN_FIELD_W-1 -: 9] == 9'h000
      && !BP_STORE_EN_OUT[NUM_STREAMS-1];
  endproperty
  a_idle_zero: assert property (p_idle_zero) else $error("idle stream used");
  property p_frame_only;
    !$stable(LOCAL_SAMPLE_POS_OUT) || !$stable(BP_CHAN_DELAY_OUT)
      || !$stable(SAMPLE_MODE_OUT) |-> $past(FRAME_START_IN, 2);
  endproperty
  a_frame_only: assert property (p_frame_only) else $error("mid-frame change");
  property p_no_store;
    FRAME_START_IN && CE_IN |=> BP_STORE_EN_OUT == 32'h0;
  endproperty
  a_no_store: assert property (p_no_store) else $error("store at boundary");
  c_wr: cover property (S_AXI_BVALID_OUT && S_AXI_BREADY_IN);
  c_rd: cover property (S_AXI_RVALID_OUT && S_AXI_RREADY_IN);
  c_store: cover property ($rose(BP_STORE_EN_OUT[0]));
endmodule

/* isd_frame_src.sv */
// Frame and channel slot source standing in for the serial receivers
`timescale 1ns/1ns
module isd_frame_src #(
  parameter int SLOT_GAP = 4,
  parameter int NSLOT    = 48
)(
  input  wire logic clk_in,
  input  wire logic rst_in,
  output logic      frame_start_out,
  output logic      chan_slot_out
);
  int cnt;
  // Slots stay clear of the boundary cycle so counts are unambiguous
  always_ff @(posedge clk_in) begin
    if (rst_in || cnt == SLOT_GAP * NSLOT - 1) begin
      cnt <= 0;
    end else begin
      cnt <= cnt + 1;
    end
  end
  assign frame_start_out = !rst_in && cnt == 0;
  assign chan_slot_out   = cnt % SLOT_GAP == SLOT_GAP - 1;
endmodule

/* isd_top_test.sv */
// Self-checking testbench for the input stream delay block
`timescale 1ns/1ns
module isd_top_test
  import isd_pkg::*;
;
  logic        clk = 1'h0, rst = 1'h1, ce = 1'h1;
  logic        awv = 1'h0, wv = 1'h0, bry = 1'h0, arv = 1'h0, rry = 1'h0;
  logic [11:0] awa = 12'h0, ara = 12'h0;
  logic [31:0] wd = 32'h0, rd;
  logic [3:0]  ws = 4'hf;
  logic [1:0]  br, rr;
  logic        awr, bv, arr, rv, fs, cs, smode;
  logic [191:0] pos;
  logic [287:0] dly;
  logic [31:0] act, sto;
  int          n_fail = 0, n_tests = 0;
  always #5 clk = ~clk;
  isd_top dut (
    .SYS_CLK_IN(clk), .RST_IN(rst), .CE_IN(ce),
    .S_AXI_AWADDR_IN(awa), .S_AXI_AWVALID_IN(awv),
    .S_AXI_AWREADY_OUT(awr), .S_AXI_WDATA_IN(wd), .S_AXI_WSTRB_IN(ws),
    .S_AXI_WVALID_IN(wv), .S_AXI_WREADY_OUT(), .S_AXI_BRESP_OUT(br),
    .S_AXI_BVALID_OUT(bv), .S_AXI_BREADY_IN(bry), .S_AXI_ARADDR_IN(ara),
    .S_AXI_ARVALID_IN(arv), .S_AXI_ARREADY_OUT(arr), .S_AXI_RDATA_OUT(rd),
    .S_AXI_RRESP_OUT(rr), .S_AXI_RVALID_OUT(rv), .S_AXI_RREADY_IN(rry),
    .FRAME_START_IN(fs), .CHAN_SLOT_IN(cs), .SAMPLE_MODE_OUT(smode),
    .LOCAL_SAMPLE_POS_OUT(pos), .BP_CHAN_DELAY_OUT(dly),
    .BP_STREAM_ACTIVE_OUT(act), .BP_STORE_EN_OUT(sto));
  isd_frame_src src (.clk_in(clk), .rst_in(rst), .frame_start_out(fs),
    .chan_slot_out(cs));
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic print_verdict();
    $display("Checks %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic tmo();
    n_fail++;
    print_verdict();
  endtask
  function automatic logic [11:0] ad(input int x);
    return 12'(x * 4);
  endfunction
  // One transfer at a time; ready lines are raised with the request
  task automatic axi(input logic w, input logic [11:0] a,
    input logic [31:0] d, output logic [31:0] q, output logic [1:0] r);
    int i;
    @(posedge clk);
    if (w) begin
      awa <= a;
      wd <= d;
      awv <= 1'h1;
      wv <= 1'h1;
      bry <= 1'h1;
      do @(posedge clk); while (awr !== 1'h1 && ++i < 99);
      awv <= 1'h0;
      wv <= 1'h0;
      while (bv !== 1'h1 && i++ < 99) @(posedge clk);
      r = br;
      bry <= 1'h0;
    end else begin
      ara <= a;
      arv <= 1'h1;
      rry <= 1'h1;
      do @(posedge clk); while (arr !== 1'h1 && ++i < 99);
      arv <= 1'h0;
      while (rv !== 1'h1 && i++ < 99) @(posedge clk);
      q = rd;
      r = rr;
      rry <= 1'h0;
    end
    if (i >= 99) tmo();
  endtask
  task automatic fr();
    int i;
    do @(posedge clk); while (fs !== 1'h1 && ++i < 999);
    if (i >= 999) tmo();
    repeat (2) @(posedge clk);
  endtask
  task automatic s_reset();
    logic [31:0] q;
    logic [1:0]  r;
    axi(1'h0, ad(IDX_BCD_FIRST), 32'h0, q, r);
    chk("first chan delay", 32'h0, q);
    axi(1'h0, ad(IDX_BCD_LAST), 32'h0, q, r);
    chk("last chan delay", 32'h0, q);
    chk("reset point", 32'h3, {26'h0, pos[5:0]});
  endtask
  task automatic s_bits();
    logic [31:0] q;
    logic [1:0]  r;
    int          qp[4] = '{3, 4, 1, 2};
    for (int s = 0; s < 32; s++) axi(1'h1, ad(IDX_LID_FIRST + s), 32'(s), q, r);
    for (int m = 0; m < 2; m++) begin
      axi(1'h1, ad(IDX_CTRL), 32'(m), q, r);
      fr();
      chk("mode", 32'(m), {31'h0, smode});
      for (int s = 0; s < 32; s++) begin
        chk("position", m ? 32'(4 * (s / 4) + qp[s % 4]) : 32'(3 + s),
          {26'h0, pos[6*s +: 6]});
      end
    end
  endtask
  task automatic s_chan();
    logic [31:0] q;
    logic [1:0]  r;
    int          lim[5] = '{31, 63, 127, 255, 511};
    fr();
    axi(1'h1, ad(IDX_BCD_FIRST), 32'h5, q, r);
    axi(1'h1, ad(IDX_BCD_FIRST + 1), 32'h1ff, q, r);
    chk("write resp", 32'(RESP_OKAY), {30'h0, r});
    axi(1'h1, ad(IDX_BCD_LAST), 32'h1ff, q, r);
    axi(1'h0, ad(IDX_BCD_FIRST + 1), 32'h0, q, r);
    chk("readback", 32'h1ff, q);
    chk("before boundary", 32'h0, {23'h0, dly[17:9]});
    for (int k = 0; k < 5; k++) begin
      axi(1'h1, ad(IDX_CTRL), 32'(k * 2), q, r);
      fr();
      chk("stream1 delay", 32'(lim[k]), {23'h0, dly[17:9]});
      chk("stream31 delay", k == 4 ? 0 : lim[k], {23'h0, dly[287:279]});
      chk("stream31 active", 32'(k != 4), {31'h0, act[31]});
    end
    // Rate codes above the top one behave as the fastest rate
    axi(1'h1, ad(IDX_CTRL), 32'he, q, r);
    fr();
    chk("rate code 7 active", 32'h0, {31'h0, act[31]});
  endtask
  task automatic s_store();
    logic [31:0] q;
    logic [1:0]  r;
    int          n;
    axi(1'h1, ad(IDX_CTRL), 32'h0, q, r);
    fr();
    for (int k = 1; k <= 6; k++) begin
      n = 0;
      do @(posedge clk); while (cs !== 1'h1 && ++n < 9);
      if (n >= 9) tmo();
      repeat (2) @(posedge clk);
      chk("store enable", 32'(k >= 5), {31'h0, sto[0]});
    end
  endtask
  task automatic s_bad();
    logic [31:0] q;
    logic [1:0]  r;
    axi(1'h1, ad(IDX_BCD_LAST + 1), 32'h1, q, r);
    chk("unmapped write", 32'(RESP_DECERR), {30'h0, r});
    axi(1'h0, ad(IDX_BCD_LAST + 1), 32'h0, q, r);
    chk("unmapped read", 32'(RESP_DECERR), {30'h0, r});
    chk("unmapped data", 32'h0, q);
    ws <= 4'h1;
    axi(1'h1, ad(IDX_BCD_FIRST + 2), 32'h1ff, q, r);
    ws <= 4'hf;
    axi(1'h0, ad(IDX_BCD_FIRST + 2), 32'h0, q, r);
    chk("strobe low lane", 32'hff, q);
  endtask
  // Clock enable low across a frame start must freeze the frame count
  task automatic s_hold();
    logic [31:0] q, f;
    logic [1:0]  r;
    fr();
    axi(1'h0, ad(IDX_STAT), 32'h0, f, r);
    ce <= 1'h0;
    repeat (200) @(posedge clk);
    chk("ready while held", 32'h0, {31'h0, arr});
    ce <= 1'h1;
    axi(1'h0, ad(IDX_STAT), 32'h0, q, r);
    chk("frame count held", {16'h0, f[31:16]}, {16'h0, q[31:16]});
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'h0;
    s_reset();
    s_bits();
    s_chan();
    s_store();
    s_hold();
    s_bad();
    print_verdict();
  end
endmodule
bind isd_top isd_sva u_sva (.SYS_CLK_IN, .RST_IN, .CE_IN, .FRAME_START_IN,
  .S_AXI_WVALID_IN, .S_AXI_WREADY_OUT,
  .S_AXI_AWVALID_IN, .S_AXI_AWREADY_OUT, .S_AXI_BRESP_OUT, .S_AXI_BVALID_OUT,
  .S_AXI_BREADY_IN, .S_AXI_ARVALID_IN, .S_AXI_ARREADY_OUT, .S_AXI_RVALID_OUT,
  .S_AXI_RREADY_IN, .SAMPLE_MODE_OUT, .LOCAL_SAMPLE_POS_OUT,
  .BP_CHAN_DELAY_OUT, .BP_STREAM_ACTIVE_OUT, .BP_STORE_EN_OUT);
